// File: common/cap_pkg.sv
/*
 * Shared constants and carrier types of the bus activity and power
 * control block. Assumes a single 100 MHz system clock.
 */
package cap_pkg;
  // Clock and timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // Delays in milliseconds or minutes, as printed
  localparam int SAMPLE_MS = 20;
  localparam int LP_DELAY_MS = 1000;
  localparam int SETTLE_MS = 50;
  localparam int WAKE_HOLD_MS = 1000;
  localparam int LED_ON_MS = 16;
  localparam int LED_PERIOD_MS = 4000;
  localparam int MS_PER_MIN = 60000;
  localparam int TO_SHORT_MIN = 2;
  localparam int TO_LONG_MIN = 10;
  localparam int TO_SHORT_MS = TO_SHORT_MIN * MS_PER_MIN;
  localparam int TO_LONG_MS = TO_LONG_MIN * MS_PER_MIN;
  // Narrowest bus pulse; one clock sample per cycle is enough
  localparam int MIN_PULSE_NS = 30;
  localparam int MIN_PULSE_CYC = MIN_PULSE_NS / CLK_PERIOD_NS;
  // Edges per sample interval for an active bus
  localparam logic [3:0] ACT_EDGES = 4'h8;
  // Configuration register selects
  localparam logic [1:0] SEL_FREQ = 2'h0;
  localparam logic [1:0] SEL_PWR_A = 2'h1;
  localparam logic [1:0] SEL_PWR_B = 2'h2;
  // Reset values
  localparam logic [7:0] FREQ_CFG_RST = 8'hFF;
  localparam logic [7:0] PWR_A_RST = 8'h80;
  localparam logic [7:0] PWR_B_RST = 8'h88;
  // Field positions
  localparam int FM_MATCH_BIT = 0;
  localparam int FM_NOSIG_BIT = 1;
  localparam int FM_STDBLK_BIT = 2;
  localparam int PA_MASTER_BIT = 7;
  localparam int PB_ACTOUT_BIT = 0;
  localparam int PB_TOSHORT_BIT = 2;
  localparam int PB_WAKE_BIT = 3;
  localparam int PB_LEDFL_BIT = 4;
  localparam int PB_MONEN_BIT = 7;
  localparam int LED_COUNT = 5;

  // Protocol search status from the interpreter
  typedef struct packed {
    logic searching;
    logic protocol_active;
    logic freq_match;
    logic no_signal;
    logic nonstd_rate;
    logic std_detected;
  } cap_search_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DELAY = 3'b001,
    ST_LED_OFF = 3'b010,
    ST_PWR1 = 3'b011,
    ST_PWR2 = 3'b100,
    ST_LOW = 3'b101,
    ST_WAKE1 = 3'b110,
    ST_WAKE2 = 3'b111
  } cap_state_t;
endpackage

// File: hdl/cap_edge_counter.sv
/*
 * Edge counter on the bus receive input, judged once per sample pulse.
 * Assumes can_rx is synchronous to clock and sample is one cycle wide.
 */
`timescale 1ns/1ns
module cap_edge_counter (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic can_rx,
  input wire logic sample,
  output logic active
);
  logic rx_prev_ff;
  logic [3:0] cnt_ff;
  logic active_ff;
  logic nxt_rx_prev;
  logic [3:0] nxt_cnt;
  logic nxt_active;
  logic edge_now;
  logic [4:0] total;

  // rising edge count
  // Saturating; an edge in the sample cycle counts there only, never twice
  always_comb begin
    edge_now = can_rx & ~rx_prev_ff;
    total = {1'b0, cnt_ff} + {4'h0, edge_now};
    nxt_rx_prev = can_rx;
    nxt_active = active_ff;
    nxt_cnt = cnt_ff;
    if (sample) begin
      nxt_active = (total >= {1'b0, cap_pkg::ACT_EDGES});
      nxt_cnt = 4'h0;
    end else if (edge_now && cnt_ff != 4'hF) begin
      nxt_cnt = total[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_prev_ff <= 1'b1; // Recessive idle, so no false edge
      cnt_ff <= 4'h0;
      active_ff <= 1'b0;
    end else begin
      rx_prev_ff <= nxt_rx_prev;
      cnt_ff <= nxt_cnt;
      active_ff <= nxt_active;
    end
  end

  assign active = active_ff;

  property p_act_thresh;
    @(posedge clock) disable iff (!rst_n)
      sample |=> (active == ($past(total) >= 5'h08));
  endproperty
  a_act_thresh: assert property (p_act_thresh) else $error("activity judged wrongly");

  property p_edge_count;
    @(posedge clock) disable iff (!rst_n)
      (!sample && edge_now && cnt_ff < 4'hF) |=> (cnt_ff == $past(cnt_ff) + 4'h1);
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("edge not counted");
endmodule

// File: hdl/cap_power_ctrl.sv
/*
 * Bus activity monitor, send permission during protocol search,
 * transceiver mode pins, control output and low power sequencer.
 * Assumes command inputs are one-cycle pulses from the interpreter
 * and all inputs are synchronous to clock.
 */
`timescale 1ns/1ns
module cap_power_ctrl #(
  parameter int CYC_PER_MS = cap_pkg::CYC_PER_MS,
  parameter int TO_SHORT_MS = cap_pkg::TO_SHORT_MS,
  parameter int TO_LONG_MS = cap_pkg::TO_LONG_MS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic can_rx,
  input wire cap_pkg::cap_search_t search,
  input wire logic bypass_initiation_cmd,
  input wire logic monitoring_mode,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  input wire logic [1:0] xcvr_mode_default,
  input wire logic transceiver_mode_cmd,
  input wire logic [1:0] transceiver_mode_num,
  input wire logic restore_defaults_cmd,
  input wire logic full_reset_cmd,
  input wire logic warm_start_cmd,
  input wire logic control_output_set_cmd,
  input wire logic control_output_level,
  input wire logic read_input_one_cmd,
  input wire logic read_input_two_cmd,
  input wire logic gp_in_one,
  input wire logic gp_in_two,
  input wire logic low_power_cmd,
  output logic send_permit,
  output logic xcvr_mode_hi,
  output logic xcvr_mode_lo,
  output logic control_out,
  output logic input_report_valid,
  output logic input_report,
  output logic [4:0] led_enable,
  output logic act_led,
  output logic pwr_ctrl_one,
  output logic pwr_ctrl_two,
  output logic reduced_power,
  output logic wake_start,
  output logic bus_active
);
  localparam int CW = $clog2(CYC_PER_MS);

  logic [CW-1:0] cyc_ff, nxt_cyc;
  logic ms_ff, nxt_ms;
  logic [4:0] samp_ff, nxt_samp;
  logic sample_ff, nxt_sample;
  logic [11:0] led_cnt_ff, nxt_led_cnt;
  logic [19:0] idle_ff, nxt_idle;
  logic [10:0] seq_ff, nxt_seq;
  logic [7:0] freq_cfg_ff, nxt_freq_cfg;
  logic [7:0] pwr_a_ff, nxt_pwr_a;
  logic [7:0] pwr_b_ff, nxt_pwr_b;
  logic bypass_ff, nxt_bypass;
  logic [1:0] mode_ff, nxt_mode;
  logic ctrl_lvl_ff, nxt_ctrl_lvl;
  logic ctrl_out_ff, nxt_ctrl_out;
  logic permit_ff, nxt_permit;
  logic rep_v_ff, nxt_rep_v;
  logic rep_ff, nxt_rep;
  logic act_prev_ff;
  logic seen_ff, nxt_seen;
  cap_pkg::cap_state_t st_ff, nxt_st;
  logic [4:0] led_ff, nxt_led;
  logic act_led_ff, nxt_act_led;
  logic p1_ff, nxt_p1;
  logic p2_ff, nxt_p2;
  logic red_ff, nxt_red;
  logic wake_ff, nxt_wake;
  logic can_active;
  logic soft_rst;
  logic master;
  logic idle_trip;
  logic [19:0] to_ms;
  logic fm_ok;

  cap_edge_counter u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .can_rx(can_rx),
    .sample(sample_ff),
    .active(can_active)
  );

  assign soft_rst = full_reset_cmd | warm_start_cmd;
  assign master = pwr_a_ff[cap_pkg::PA_MASTER_BIT];

  always_comb begin
    nxt_ms = 1'b0;
    nxt_cyc = cyc_ff + CW'(1);
    if (cyc_ff == CW'(CYC_PER_MS - 1)) begin
      nxt_cyc = '0;
      nxt_ms = 1'b1;
    end
    nxt_sample = 1'b0;
    nxt_samp = samp_ff;
    if (ms_ff) begin
      nxt_samp = samp_ff + 5'h01;
      if (samp_ff == 5'(cap_pkg::SAMPLE_MS - 1)) begin
        nxt_samp = 5'h00;
        nxt_sample = 1'b1;
      end
    end
    nxt_led_cnt = led_cnt_ff;
    if (ms_ff) begin
      nxt_led_cnt = (led_cnt_ff == 12'(cap_pkg::LED_PERIOD_MS - 1)) ? 12'h000
                                                                   : led_cnt_ff + 12'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cyc_ff <= '0;
      ms_ff <= 1'b0;
      samp_ff <= 5'h00;
      sample_ff <= 1'b0;
      led_cnt_ff <= 12'h000;
    end else begin
      cyc_ff <= nxt_cyc;
      ms_ff <= nxt_ms;
      samp_ff <= nxt_samp;
      sample_ff <= nxt_sample;
      led_cnt_ff <= nxt_led_cnt;
    end
  end

  // Configuration, mode pins, control output, input reads, send permit
  always_comb begin
    nxt_freq_cfg = freq_cfg_ff;
    nxt_pwr_a = pwr_a_ff;
    nxt_pwr_b = pwr_b_ff;
    if (cfg_wr && cfg_sel == cap_pkg::SEL_FREQ) nxt_freq_cfg = cfg_wdata;
    if (cfg_wr && cfg_sel == cap_pkg::SEL_PWR_A) nxt_pwr_a = cfg_wdata;
    if (cfg_wr && cfg_sel == cap_pkg::SEL_PWR_B) nxt_pwr_b = cfg_wdata;
    nxt_bypass = (bypass_ff | bypass_initiation_cmd) & ~soft_rst;
    nxt_mode = mode_ff;
    if (restore_defaults_cmd || soft_rst) begin
      nxt_mode = xcvr_mode_default;
    end else if (transceiver_mode_cmd) begin
      nxt_mode = transceiver_mode_num;
    end
    nxt_ctrl_lvl = ctrl_lvl_ff;
    if (soft_rst) begin
      nxt_ctrl_lvl = 1'b0;
    end else if (control_output_set_cmd) begin
      nxt_ctrl_lvl = control_output_level;
    end
    nxt_ctrl_out = pwr_b_ff[cap_pkg::PB_ACTOUT_BIT] ? can_active : nxt_ctrl_lvl;
    nxt_rep_v = read_input_one_cmd | read_input_two_cmd;
    nxt_rep = rep_ff;
    if (read_input_one_cmd) begin
      nxt_rep = gp_in_one;
    end else if (read_input_two_cmd) begin
      nxt_rep = gp_in_two;
    end
    fm_ok = ((search.freq_match & freq_cfg_ff[cap_pkg::FM_MATCH_BIT])
            | (search.no_signal & freq_cfg_ff[cap_pkg::FM_NOSIG_BIT]))
            & ~(freq_cfg_ff[cap_pkg::FM_STDBLK_BIT] & search.nonstd_rate
            & search.std_detected);
    nxt_permit = ~search.searching | search.protocol_active | nxt_bypass | fm_ok;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      freq_cfg_ff <= cap_pkg::FREQ_CFG_RST;
      pwr_a_ff <= cap_pkg::PWR_A_RST;
      pwr_b_ff <= cap_pkg::PWR_B_RST;
      bypass_ff <= 1'b0;
      mode_ff <= xcvr_mode_default;
      ctrl_lvl_ff <= 1'b0;
      ctrl_out_ff <= 1'b0;
      permit_ff <= 1'b0;
      rep_v_ff <= 1'b0;
      rep_ff <= 1'b0;
    end else begin
      freq_cfg_ff <= nxt_freq_cfg;
      pwr_a_ff <= nxt_pwr_a;
      pwr_b_ff <= nxt_pwr_b;
      bypass_ff <= nxt_bypass;
      mode_ff <= nxt_mode;
      ctrl_lvl_ff <= nxt_ctrl_lvl;
      ctrl_out_ff <= nxt_ctrl_out;
      permit_ff <= nxt_permit;
      rep_v_ff <= nxt_rep_v;
      rep_ff <= nxt_rep;
    end
  end

  assign to_ms = pwr_b_ff[cap_pkg::PB_TOSHORT_BIT] ? 20'(TO_SHORT_MS) : 20'(TO_LONG_MS);
  // loss of activity trips entry when monitor enabled
  assign idle_trip = pwr_b_ff[cap_pkg::PB_MONEN_BIT] & ~monitoring_mode & (idle_ff >= to_ms);

  // Low power sequencer; waits counted in ms so the tick sets resolution
  always_comb begin
    nxt_st = st_ff;
    nxt_seq = seq_ff;
    nxt_led = led_ff;
    nxt_act_led = 1'b0;
    nxt_p1 = p1_ff;
    nxt_p2 = p2_ff;
    nxt_red = red_ff;
    nxt_wake = 1'b0;
    nxt_seen = seen_ff | (can_active & (st_ff == cap_pkg::ST_RUN));
    nxt_idle = idle_ff;
    if (can_active || st_ff != cap_pkg::ST_RUN) begin
      nxt_idle = 20'h00000;
    end else if (ms_ff && idle_ff != 20'hFFFFF) begin
      nxt_idle = idle_ff + 20'h00001;
    end
    if (ms_ff) nxt_seq = seq_ff + 11'h001;
    case (st_ff)
      cap_pkg::ST_RUN: begin
        if (master && (low_power_cmd || idle_trip)) begin
          nxt_st = cap_pkg::ST_DELAY;
          nxt_seq = 11'h000;
        end
      end
      cap_pkg::ST_DELAY: begin
        if (seq_ff >= 11'(cap_pkg::LP_DELAY_MS)) nxt_st = cap_pkg::ST_LED_OFF;
      end
      cap_pkg::ST_LED_OFF: begin
        nxt_led = 5'h00;
        nxt_st = cap_pkg::ST_PWR1;
        nxt_seq = 11'h000;
      end
      cap_pkg::ST_PWR1: begin
        nxt_p1 = 1'b0;
        if (seq_ff >= 11'(cap_pkg::SETTLE_MS)) begin
          nxt_p2 = 1'b0;
          nxt_st = cap_pkg::ST_PWR2;
          nxt_seq = 11'h000;
        end
      end
      cap_pkg::ST_PWR2: begin
        if (seq_ff >= 11'(cap_pkg::SETTLE_MS)) begin
          nxt_red = 1'b1;
          nxt_st = cap_pkg::ST_LOW;
        end
      end
      cap_pkg::ST_LOW: begin
        // flash per monitor level or config bit
        if (led_cnt_ff < 12'(cap_pkg::LED_ON_MS)) begin
          nxt_act_led = seen_ff ? pwr_b_ff[cap_pkg::PB_LEDFL_BIT] : can_rx;
        end
        // wake on activity rise when permitted
        if (can_active && !act_prev_ff && (pwr_b_ff[cap_pkg::PB_WAKE_BIT] || seen_ff)) begin
          nxt_red = 1'b0;
          nxt_p1 = 1'b1;
          nxt_st = cap_pkg::ST_WAKE1;
          nxt_seq = 11'h000;
        end
      end
      cap_pkg::ST_WAKE1: begin
        if (seq_ff >= 11'(cap_pkg::SETTLE_MS)) begin
          nxt_p2 = 1'b1;
          nxt_st = cap_pkg::ST_WAKE2;
          nxt_seq = 11'h000;
        end
      end
      cap_pkg::ST_WAKE2: begin
        if (seq_ff >= 11'(cap_pkg::WAKE_HOLD_MS)) begin
          nxt_led = 5'h1F;
          nxt_wake = 1'b1;
          nxt_seen = 1'b0;
          nxt_st = cap_pkg::ST_RUN;
        end
      end
      default: nxt_st = cap_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= cap_pkg::ST_RUN;
      seq_ff <= 11'h000;
      led_ff <= 5'h1F;
      act_led_ff <= 1'b0;
      p1_ff <= 1'b1;
      p2_ff <= 1'b1;
      red_ff <= 1'b0;
      wake_ff <= 1'b0;
      seen_ff <= 1'b0;
      idle_ff <= 20'h00000;
      act_prev_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      seq_ff <= nxt_seq;
      led_ff <= nxt_led;
      act_led_ff <= nxt_act_led;
      p1_ff <= nxt_p1;
      p2_ff <= nxt_p2;
      red_ff <= nxt_red;
      wake_ff <= nxt_wake;
      seen_ff <= nxt_seen;
      idle_ff <= nxt_idle;
      act_prev_ff <= can_active;
    end
  end

  // mode pins held
  // All outputs straight from flip-flops; mode pins untouched by sequencer
  assign send_permit = permit_ff;
  assign xcvr_mode_hi = mode_ff[1];
  assign xcvr_mode_lo = mode_ff[0];
  assign control_out = ctrl_out_ff;
  assign input_report_valid = rep_v_ff;
  assign input_report = rep_ff;
  assign led_enable = led_ff;
  assign act_led = act_led_ff;
  assign pwr_ctrl_one = p1_ff;
  assign pwr_ctrl_two = p2_ff;
  assign reduced_power = red_ff;
  assign wake_start = wake_ff;
  assign bus_active = act_prev_ff;

  property p_mode_cmd;
    @(posedge clock) disable iff (!rst_n)
      (transceiver_mode_cmd && !restore_defaults_cmd && !soft_rst)
      |=> ({xcvr_mode_hi, xcvr_mode_lo} == $past(transceiver_mode_num));
  endproperty
  a_mode_cmd: assert property (p_mode_cmd) else $error("mode pins wrong");
  property p_mode_dflt;
    @(posedge clock) disable iff (!rst_n)
      restore_defaults_cmd |=> ({xcvr_mode_hi, xcvr_mode_lo} == $past(xcvr_mode_default));
  endproperty
  a_mode_dflt: assert property (p_mode_dflt) else $error("default not loaded");
  property p_mode_hold;
    @(posedge clock) disable iff (!rst_n)
      (st_ff == cap_pkg::ST_LOW && !transceiver_mode_cmd && !restore_defaults_cmd
       && !soft_rst) |=> $stable(mode_ff);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed in low power");
  property p_bypass;
    @(posedge clock) disable iff (!rst_n)
      (bypass_initiation_cmd && !soft_rst) |=> send_permit;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not permit");
  property p_std_block;
    @(posedge clock) disable iff (!rst_n)
      (search.searching && !search.protocol_active && !nxt_bypass && search.nonstd_rate
       && search.std_detected && freq_cfg_ff[cap_pkg::FM_STDBLK_BIT]) |=> !send_permit;
  endproperty
  a_std_block: assert property (p_std_block) else $error("send not blocked");
  property p_ctrl_rst;
    @(posedge clock) disable iff (!rst_n)
      (soft_rst && !pwr_b_ff[cap_pkg::PB_ACTOUT_BIT]) |=> !control_out;
  endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("control not low");
  property p_act_out;
    @(posedge clock) disable iff (!rst_n)
      pwr_b_ff[cap_pkg::PB_ACTOUT_BIT] |=> (control_out == $past(can_active));
  endproperty
  a_act_out: assert property (p_act_out) else $error("activity not on control");
  property p_master;
    @(posedge clock) disable iff (!rst_n)
      (st_ff == cap_pkg::ST_RUN && !master) |=> (st_ff == cap_pkg::ST_RUN);
  endproperty
  a_master: assert property (p_master) else $error("entry without master");
  property p_seq;
    @(posedge clock) disable iff (!rst_n)
      (st_ff == cap_pkg::ST_LED_OFF) |=> (led_enable == 5'h00 && pwr_ctrl_two)
      ##1 !pwr_ctrl_one;
  endproperty
  a_seq: assert property (p_seq) else $error("entry order wrong");
  c_entry: cover property (@(posedge clock) disable iff (!rst_n) st_ff == cap_pkg::ST_LOW);
  c_wake: cover property (@(posedge clock) disable iff (!rst_n) wake_start);
  c_block: cover property (@(posedge clock) disable iff (!rst_n)
    search.searching && !send_permit);
endmodule

// File: verification/cap_bus_model.sv
/*
 * Far side of the bus activity input: a receive line that either idles
 * or carries one narrow pulse per period. Assumes one system clock and a
 * bench that changes period or idle level only between bursts.
 */
`timescale 1ns/1ns
module cap_bus_model (
  input wire logic clock,
  input wire logic [15:0] period,
  input wire logic idle_level,
  output logic can_rx
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;

  // Period counter; zero period means a silent bus
  always_comb begin
    nxt_cnt = cnt_ff + 16'h0001;
    if (period == 16'h0000 || cnt_ff >= period - 16'h0001) begin
      nxt_cnt = 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    cnt_ff <= nxt_cnt;
  end

  // One-cycle pulse: the narrowest edge the clock can carry
  assign can_rx = (period == 16'h0000) ? idle_level : (cnt_ff == 16'h0000);
endmodule

// File: verification/tb_cap_power_ctrl.sv
/*
 * Self-checking bench of the activity and power control block.
 * Assumes a 100 MHz clock and a shortened millisecond tick.
 */
`timescale 1ns/1ns
module tb_cap_power_ctrl;
  localparam int CPM = 10;
  localparam int LP = cap_pkg::LP_DELAY_MS * CPM;
  localparam int ST = cap_pkg::SETTLE_MS * CPM;
  typedef struct packed {
    logic [5:0] srch;
    logic [1:0] mode;
    logic permit;
  } cap_row_t;
  cap_row_t rows [6] = '{'{6'h20, 2'h0, 1'h0}, '{6'h28, 2'h1, 1'h1}, '{6'h24, 2'h2, 1'h1},
    '{6'h2B, 2'h3, 1'h0}, '{6'h30, 2'h1, 1'h1}, '{6'h00, 2'h3, 1'h1}};
  logic clock, rst_n, can_rx, monitoring_mode, cfg_wr, transceiver_mode_cmd, idle_level;
  logic bypass_initiation_cmd, restore_defaults_cmd, full_reset_cmd, warm_start_cmd;
  logic control_output_set_cmd, control_output_level, read_input_one_cmd, read_input_two_cmd;
  logic gp_in_one, gp_in_two, low_power_cmd;
  logic [1:0] cfg_sel, transceiver_mode_num, xcvr_mode_default;
  logic [7:0] cfg_wdata;
  logic [15:0] period;
  cap_pkg::cap_search_t search;
  logic send_permit, xcvr_mode_hi, xcvr_mode_lo, control_out, input_report_valid;
  logic input_report, act_led, pwr_ctrl_one, pwr_ctrl_two, reduced_power, wake_start, bus_active;
  logic [4:0] led_enable;
  int fail_count, comparisons, n;

  cap_bus_model i_cap_bus_model (.clock(clock), .period(period), .idle_level(idle_level),
    .can_rx(can_rx));
  cap_power_ctrl #(.CYC_PER_MS(CPM), .TO_SHORT_MS(20), .TO_LONG_MS(40)) i_cap_power_ctrl (
    .clock(clock), .rst_n(rst_n), .can_rx(can_rx), .search(search),
    .bypass_initiation_cmd(bypass_initiation_cmd), .monitoring_mode(monitoring_mode),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .xcvr_mode_default(xcvr_mode_default),
    .transceiver_mode_cmd(transceiver_mode_cmd), .transceiver_mode_num(transceiver_mode_num),
    .restore_defaults_cmd(restore_defaults_cmd), .full_reset_cmd(full_reset_cmd),
    .warm_start_cmd(warm_start_cmd), .control_output_set_cmd(control_output_set_cmd),
    .control_output_level(control_output_level), .read_input_one_cmd(read_input_one_cmd),
    .read_input_two_cmd(read_input_two_cmd), .gp_in_one(gp_in_one), .gp_in_two(gp_in_two),
    .low_power_cmd(low_power_cmd), .send_permit(send_permit), .xcvr_mode_hi(xcvr_mode_hi),
    .xcvr_mode_lo(xcvr_mode_lo), .control_out(control_out),
    .input_report_valid(input_report_valid), .input_report(input_report),
    .led_enable(led_enable), .act_led(act_led), .pwr_ctrl_one(pwr_ctrl_one),
    .pwr_ctrl_two(pwr_ctrl_two), .reduced_power(reduced_power), .wake_start(wake_start),
    .bus_active(bus_active));

  // Free-running system clock
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // Inputs move 1 ns after the edge, never on it
  task tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task chk_bit(input logic a, input logic e);
    comparisons++;
    if (a !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask

  task chk_vec(input logic [4:0] a, input logic [4:0] e);
    comparisons++;
    if (a !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(1);
  endtask

  task cfg(input logic [1:0] s, input logic [7:0] d);
    cfg_sel = s;
    cfg_wdata = d;
    pulse(cfg_wr);
  endtask

  // Bounded wait; n tells how long it took
  task wait_led(input logic [4:0] v, input int lim);
    n = 0;
    while (led_enable !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  // Valid is a one-cycle pulse, so it is caught in a short loop
  task automatic read_chk(ref logic c, input logic e);
    c = 1'h1;
    tick(1);
    c = 1'h0;
    n = 0;
    while (input_report_valid !== 1'h1 && n < 3) begin
      tick(1);
      n++;
    end
    chk_bit(input_report_valid, 1'h1);
    chk_bit(input_report, e);
  endtask

  task final_report;
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog, well above the roughly 45k cycles of the sequence
  initial begin
    repeat (80000) @(posedge clock);
    fail_count++;
    final_report();
  end

  initial begin
    {rst_n, cfg_wr, transceiver_mode_cmd, bypass_initiation_cmd, idle_level} = 5'h00;
    {restore_defaults_cmd, full_reset_cmd, warm_start_cmd, control_output_set_cmd} = 4'h0;
    {control_output_level, read_input_one_cmd, read_input_two_cmd, low_power_cmd} = 4'h0;
    {gp_in_one, gp_in_two, cfg_sel, transceiver_mode_num} = 6'h00;
    {cfg_wdata, period} = 24'h000000;
    search = '0;
    xcvr_mode_default = 2'h2;
    // Monitoring mode keeps the idle timeout out of the early tests
    monitoring_mode = 1'h1;
    tick(20);
    rst_n = 1'h1;
    tick(2);
    chk_vec({3'h0, xcvr_mode_hi, xcvr_mode_lo}, 5'h02);
    chk_bit(control_out, 1'h0);
    chk_vec(led_enable, 5'h1F);
    // Table rows: search status and mode command
    foreach (rows[i]) begin
      search = cap_pkg::cap_search_t'(rows[i].srch);
      transceiver_mode_num = rows[i].mode;
      pulse(transceiver_mode_cmd);
      tick(1);
      chk_bit(send_permit, rows[i].permit);
      chk_vec({3'h0, xcvr_mode_hi, xcvr_mode_lo}, {3'h0, rows[i].mode});
    end
    // Bypass skips the test until a warm start clears it
    search = 6'h20;
    pulse(bypass_initiation_cmd);
    tick(1);
    chk_bit(send_permit, 1'h1);
    pulse(warm_start_cmd);
    tick(1);
    chk_bit(send_permit, 1'h0);
    cfg(cap_pkg::SEL_FREQ, 8'hFD);
    search = 6'h24;
    tick(2);
    chk_bit(send_permit, 1'h0);
    cfg(cap_pkg::SEL_FREQ, 8'hFF);
    tick(2);
    chk_bit(send_permit, 1'h1);
    // A changed stored default must show up on the pins
    xcvr_mode_default = 2'h1;
    pulse(restore_defaults_cmd);
    tick(1);
    chk_vec({3'h0, xcvr_mode_hi, xcvr_mode_lo}, 5'h01);
    xcvr_mode_default = 2'h2;
    {gp_in_one, gp_in_two} = 2'h2;
    read_chk(read_input_one_cmd, 1'h1);
    read_chk(read_input_two_cmd, 1'h0);
    // Control output set, then cleared by each reset command
    control_output_level = 1'h1;
    pulse(control_output_set_cmd);
    tick(1);
    chk_bit(control_out, 1'h1);
    pulse(full_reset_cmd);
    tick(1);
    chk_bit(control_out, 1'h0);
    pulse(control_output_set_cmd);
    pulse(warm_start_cmd);
    tick(1);
    chk_bit(control_out, 1'h0);
    // Seven edges at most per interval, then exactly eight
    period = 16'd29;
    tick(1000);
    chk_bit(bus_active, 1'h0);
    period = 16'd25;
    tick(600);
    chk_bit(bus_active, 1'h1);
    cfg(cap_pkg::SEL_PWR_B, 8'h89);
    tick(2);
    chk_bit(control_out, 1'h1);
    cfg(cap_pkg::SEL_PWR_B, 8'h88);
    // Master bit off: command refused
    cfg(cap_pkg::SEL_PWR_A, 8'h00);
    pulse(low_power_cmd);
    tick(LP + 200);
    chk_vec(led_enable, 5'h1F);
    cfg(cap_pkg::SEL_PWR_A, 8'h80);
    pulse(low_power_cmd);
    tick(LP - 100);
    chk_vec(led_enable, 5'h1F);
    wait_led(5'h00, 300);
    chk_vec(led_enable, 5'h00);
    tick(3);
    chk_bit(pwr_ctrl_one, 1'h0);
    tick(ST - 25);
    chk_bit(pwr_ctrl_two, 1'h1);
    tick(40);
    chk_bit(pwr_ctrl_two, 1'h0);
    tick(ST - 40);
    chk_bit(reduced_power, 1'h0);
    tick(40);
    chk_bit(reduced_power, 1'h1);
    chk_vec({3'h0, xcvr_mode_hi, xcvr_mode_lo}, 5'h02);
    chk_bit(act_led, 1'h0);
    // Bus falls silent, then activity returns and wakes the block
    period = 16'd0;
    tick(600);
    period = 16'd25;
    n = 0;
    while (reduced_power !== 1'h0 && n < 800) begin
      tick(1);
      n++;
    end
    chk_bit(pwr_ctrl_one, 1'h1);
    tick(ST - 25);
    chk_bit(pwr_ctrl_two, 1'h0);
    tick(40);
    chk_bit(pwr_ctrl_two, 1'h1);
    wait_led(5'h1F, LP + 100);
    chk_vec(led_enable, 5'h1F);
    chk_bit(wake_start, 1'h1);
    chk_bit(n > LP - 100, 1'h1);
    // Short idle timeout, then silence starts entry
    monitoring_mode = 1'h0;
    cfg(cap_pkg::SEL_PWR_B, 8'h8C);
    period = 16'd0;
    // Time from activity loss: 20 ms idle plus 1 s grace, not 40 ms
    n = 0;
    while (bus_active !== 1'h0 && n < 500) begin
      tick(1);
      n++;
    end
    chk_bit(bus_active, 1'h0);
    wait_led(5'h00, LP + 1500);
    chk_vec(led_enable, 5'h00);
    chk_bit(n > LP + 100 && n < LP + 300, 1'h1);
    final_report();
  end
endmodule
